// ---- include/sslsq_pkg.sv ----
// shared constants for the synthesizer serial load sequencer
`default_nettype none
package sslsq_pkg;
  localparam int unsigned WORD_W        = 24;            // serial word length
  localparam int unsigned SEL_LO_POS    = 0;             // latch select low bit
  localparam int unsigned SEL_HI_POS    = 1;             // latch select high bit
  localparam int unsigned CNT_RST_POS   = 2;             // counter reset bit in function word
  localparam int unsigned MUX_LO_POS    = 4;             // monitor select field low bit
  localparam int unsigned MUX_W         = 3;             // monitor select field width
  localparam logic [1:0]  SEL_REF       = 2'h0;          // reference counter latch
  localparam logic [1:0]  SEL_AB        = 2'h1;          // ab counter latch
  localparam logic [1:0]  SEL_FUNC      = 2'h2;          // function latch
  localparam logic [1:0]  SEL_INIT      = 2'h3;          // initialization latch
  localparam logic [23:0] LATCH_RST     = 24'h000000;    // latch reset value
  localparam logic [2:0]  MUX_LOCK      = 3'h1;          // monitor shows lock indication
  localparam logic [2:0]  MUX_REF_DIV   = 3'h2;          // monitor shows reference counter wrap
  localparam logic [2:0]  MUX_AB_DIV    = 3'h4;          // monitor shows ab counter wrap
  localparam logic [2:0]  MUX_ONE       = 3'h6;          // monitor driven high
  localparam logic [2:0]  MUX_RUN       = 3'h7;          // monitor shows counters running
  localparam int unsigned SCLK_MAX_MHZ  = 20;            // fastest legal serial clock
  localparam int unsigned SETTLE_NS     = 1000;          // bias settle time after enable
  localparam int unsigned CLK_MHZ       = 40;            // core clock rate
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000; // cycles, rounded up
  localparam int unsigned CNT_W         = 14;            // width of modelled counters
  typedef enum logic [2:0] {
    SSL_OFF_type_s = 3'h1,  // powered down
    SSL_HOLD       = 3'h2,  // counters held at load point
    SSL_RUN        = 3'h4   // counting
  } sslsq_state_type;
endpackage
`default_nettype wire

// ---- rtl/sslsq_shifter.sv ----
// link-side serial input register, clocked by the serial clock
`timescale 1ns/1ps
`default_nettype none
module sslsq_shifter (
  input  wire logic                     serial_clock,  // host serial clock
  input  wire logic                     resetn,        // asynchronous reset, active low
  input  wire logic                     serial_in,     // serial data, msb first
  input  wire logic                     latch_strobe,  // level from the pin
  output logic [sslsq_pkg::WORD_W-1:0]  shift_word     // captured bits
);
  import sslsq_pkg::*;
  logic [WORD_W-1:0] shift_ff;      // shift register
  logic [WORD_W-1:0] nxt_shift;     // next shift value

  // shift only while the strobe is low; a high strobe freezes the word for the core
  always_comb begin
    nxt_shift = shift_ff;
    if (!latch_strobe) begin
      nxt_shift = {shift_ff[WORD_W-2:0], serial_in}; // [RQ8] [RQ17]
    end
  end

  // register stays alive in every power state [RQ16]
  always_ff @(posedge serial_clock or negedge resetn) begin
    if (!resetn) begin
      shift_ff <= LATCH_RST;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  assign shift_word = shift_ff;
endmodule
`default_nettype wire

// ---- rtl/sslsq_core.sv ----
// serial load sequencer top: latches, power control, counter sequencing, monitor output
// Overview of operation
// [RQ1] chip enable low powers down immediately
// [RQ2] host: ce low, load func, ref, ab
// [RQ3] ce high restarts counters in alignment
// [RQ4] host waits about 1 us after ce
// [RQ5] latches kept through chip enable cycles
// [RQ6] host: reset bit set, loads, then cleared
// [RQ7] reset bit holds counters, no power-down
// [RQ8] shift on rising clock, load on strobe
// [RQ9] host serial clock at most 20 MHz; the bench host model runs at about 20.8 MHz
// [RQ10] host sends three bytes, then raises strobe
// [RQ11] host writes all three latches first
// [RQ12] host serial master uses clock phase zero
// [RQ13] monitor output selectable, includes lock
// [RQ14] two low bits choose the latch
// [RQ15] function bit two resets both counters
// [RQ16] input register active during power-down
// [RQ17] words arrive msb first, select last
`timescale 1ns/1ps
`default_nettype none
module sslsq_core (
  input  wire logic                     clock,                  // 40 MHz core clock
  input  wire logic                     resetn,                 // asynchronous reset, active low
  input  wire logic                     serial_clock,           // host serial clock
  input  wire logic                     serial_in,              // serial data pin
  input  wire logic                     latch_strobe,           // latch strobe pin
  input  wire logic                     chip_enable,            // chip enable pin
  input  wire logic                     lock_indicator,         // lock detect from loop
  output logic                          selectable_monitor_out, // multiplexed output
  output logic                          powered_down,           // device in power-down
  output logic                          counters_held,          // counters at load point
  output logic                          charge_pump_off,        // charge pump three-stated
  output logic                          bias_settled,           // bias settle time elapsed
  output logic [sslsq_pkg::WORD_W-1:0]  ref_latch,              // reference counter latch
  output logic [sslsq_pkg::WORD_W-1:0]  ab_latch,               // ab counter latch
  output logic [sslsq_pkg::WORD_W-1:0]  func_latch              // function latch
);
  import sslsq_pkg::*;
  logic [WORD_W-1:0] shift_word;       // link-domain word, stable while strobe high
  logic [2:0]        strobe_sync_ff;   // strobe synchroniser plus edge stage
  logic [2:0]        nxt_strobe_sync;
  logic [1:0]        ce_sync_ff;       // chip enable synchroniser
  logic [1:0]        nxt_ce_sync;
  logic [1:0]        lock_sync_ff;     // lock synchroniser
  logic [1:0]        nxt_lock_sync;
  logic [WORD_W-1:0] ref_ff, ab_ff, func_ff;
  logic [WORD_W-1:0] nxt_ref, nxt_ab, nxt_func;
  logic              init_pend_ff, nxt_init_pend; // first ab load after init resets
  logic              init_pulse_ff, nxt_init_pulse;
  sslsq_state_type   state_ff, nxt_state;
  logic [CNT_W-1:0]  rcnt_ff, nxt_rcnt, abcnt_ff, nxt_abcnt;
  logic [7:0]        settle_ff, nxt_settle;
  logic              mon_ff, nxt_mon;
  logic              pdn_ff, nxt_pdn;         // registered power-down flag
  logic              held_ff, nxt_held;       // registered counter hold flag
  logic              settled_ff, nxt_settled; // registered bias settle flag
  logic              load_evt;         // strobe rising, word safe to sample
  logic              ce_now;           // synchronised chip enable

  sslsq_shifter sslsq_shifter_i (
    .serial_clock (serial_clock),
    .resetn       (resetn),
    .serial_in    (serial_in),
    .latch_strobe (latch_strobe),
    .shift_word   (shift_word)
  );

  // synchronisers: first stage feeds only the second
  always_comb begin
    nxt_strobe_sync = {strobe_sync_ff[1:0], latch_strobe};
    nxt_ce_sync     = {ce_sync_ff[0], chip_enable};
    nxt_lock_sync   = {lock_sync_ff[0], lock_indicator};
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strobe_sync_ff <= 3'h7; // idle-high strobe: reset to its idle level so release fakes no load
      ce_sync_ff     <= 2'h0;
      lock_sync_ff   <= 2'h0;
    end else begin
      strobe_sync_ff <= nxt_strobe_sync;
      ce_sync_ff     <= nxt_ce_sync;
      lock_sync_ff   <= nxt_lock_sync;
    end
  end
  // the word is frozen while strobe is high, so sampling it after sync is safe
  assign load_evt = strobe_sync_ff[1] && !strobe_sync_ff[2]; // [RQ8]
  assign ce_now   = ce_sync_ff[1];

  // latch loads; latches never clear on power-down, only on reset
  always_comb begin
    nxt_ref        = ref_ff;
    nxt_ab         = ab_ff;
    nxt_func       = func_ff;
    nxt_init_pend  = init_pend_ff;
    nxt_init_pulse = 1'b0;
    if (load_evt) begin // [RQ16] loads accepted whatever the power state
      case (shift_word[SEL_HI_POS:SEL_LO_POS]) // [RQ14]
        SEL_REF: nxt_ref = shift_word;
        SEL_AB: begin
          nxt_ab = shift_word;
          if (init_pend_ff) begin
            nxt_init_pulse = 1'b1;
            nxt_init_pend  = 1'b0;
          end
        end
        SEL_FUNC: nxt_func = shift_word;
        default: begin
          nxt_func       = shift_word; // init latch also loads function
          nxt_init_pulse = 1'b1;
          nxt_init_pend  = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_ff        <= LATCH_RST;
      ab_ff         <= LATCH_RST;
      func_ff       <= LATCH_RST;
      init_pend_ff  <= 1'b0;
      init_pulse_ff <= 1'b0;
    end else begin
      ref_ff        <= nxt_ref;  // [RQ5]
      ab_ff         <= nxt_ab;
      func_ff       <= nxt_func;
      init_pend_ff  <= nxt_init_pend;
      init_pulse_ff <= nxt_init_pulse;
    end
  end

  // power and counter state machine; both counters restart from zero together
  always_comb begin
    nxt_state  = state_ff;
    nxt_rcnt   = rcnt_ff;
    nxt_abcnt  = abcnt_ff;
    nxt_settle = settle_ff;
    // pin checked raw too so power-down does not wait on the synchroniser
    if (!chip_enable || !ce_now) begin
      nxt_state  = SSL_OFF_type_s; // [RQ1]
      nxt_settle = 8'h0;
    end else if (func_ff[CNT_RST_POS] || init_pulse_ff) begin
      nxt_state = SSL_HOLD; // [RQ15] [RQ7]
    end else begin
      nxt_state = SSL_RUN;
    end
    // raw pin too, so the count cannot creep on while power-down is entered
    if (settle_ff != SETTLE_CYC[7:0] && ce_now && chip_enable) begin
      nxt_settle = settle_ff + 8'h1;
    end
    if (nxt_state == SSL_RUN && state_ff == SSL_RUN) begin
      nxt_rcnt  = (rcnt_ff  == ref_ff[CNT_W+1:2]) ? '0 : rcnt_ff + 1'b1;
      nxt_abcnt = (abcnt_ff == ab_ff[CNT_W+1:2])  ? '0 : abcnt_ff + 1'b1;
    end else begin
      nxt_rcnt  = '0; // [RQ3] held at load point, aligned restart
      nxt_abcnt = '0;
    end
    // status flags taken from the next state so the pins come straight from flops
    nxt_pdn     = (nxt_state == SSL_OFF_type_s); // [RQ1]
    nxt_held    = (nxt_state != SSL_RUN);        // [RQ7]
    nxt_settled = (nxt_settle == SETTLE_CYC[7:0]);
  end

  // monitor select from the function latch
  always_comb begin
    case (func_ff[MUX_LO_POS +: MUX_W]) // [RQ13]
      MUX_LOCK:    nxt_mon = lock_sync_ff[1];
      MUX_REF_DIV: nxt_mon = (rcnt_ff == '0) && (state_ff == SSL_RUN);
      MUX_AB_DIV:  nxt_mon = (abcnt_ff == '0) && (state_ff == SSL_RUN);
      MUX_ONE:     nxt_mon = 1'b1;
      MUX_RUN:     nxt_mon = (state_ff == SSL_RUN);
      default:     nxt_mon = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff  <= SSL_OFF_type_s;
      rcnt_ff   <= '0;
      abcnt_ff  <= '0;
      settle_ff <= 8'h0;
      mon_ff    <= 1'b0;
      pdn_ff     <= 1'b1;
      held_ff    <= 1'b1;
      settled_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      rcnt_ff   <= nxt_rcnt;
      abcnt_ff  <= nxt_abcnt;
      settle_ff <= nxt_settle;
      mon_ff    <= nxt_mon;
      pdn_ff     <= nxt_pdn;
      held_ff    <= nxt_held;
      settled_ff <= nxt_settled;
    end
  end

  // outputs straight from flip-flops
  assign selectable_monitor_out = mon_ff;
  assign powered_down           = pdn_ff;
  assign counters_held          = held_ff;
  assign charge_pump_off        = held_ff;
  assign bias_settled           = settled_ff;
  assign ref_latch              = ref_ff;
  assign ab_latch               = ab_ff;
  assign func_latch             = func_ff;

  // checks
  chk_ce_powerdown: assert property (@(posedge clock) disable iff (!resetn)
    !chip_enable |=> powered_down) else $error("chip enable low did not power down"); // [RQ1]
  chk_reset_hold: assert property (@(posedge clock) disable iff (!resetn)
    (func_ff[CNT_RST_POS] && ce_now && chip_enable) |=> (counters_held && !powered_down))
    else $error("counter reset bit not honoured"); // [RQ7]
  chk_counts_zero: assert property (@(posedge clock) disable iff (!resetn)
    counters_held |-> (rcnt_ff == '0 && abcnt_ff == '0)) else $error("counters not at load point"); // [RQ15]
  chk_aligned_start: assert property (@(posedge clock) disable iff (!resetn)
    ($rose(state_ff == SSL_RUN)) |-> (rcnt_ff == abcnt_ff)) else $error("counters restarted misaligned"); // [RQ3]
  chk_latch_keep: assert property (@(posedge clock) disable iff (!resetn)
    !load_evt |=> $stable(func_ff) && $stable(ref_ff)) else $error("latch changed without load"); // [RQ5]
  chk_func_load: assert property (@(posedge clock) disable iff (!resetn)
    (load_evt && shift_word[1:0] == SEL_FUNC) |=> func_ff == $past(shift_word))
    else $error("function latch load wrong"); // [RQ14]
  chk_ref_load: assert property (@(posedge clock) disable iff (!resetn)
    (load_evt && shift_word[1:0] == SEL_REF) |=> ref_ff == $past(shift_word))
    else $error("reference latch load wrong"); // [RQ8]
  chk_load_down: assert property (@(posedge clock) disable iff (!resetn)
    (load_evt && powered_down && shift_word[1:0] == SEL_AB) |=> ab_ff == $past(shift_word))
    else $error("load lost during power-down"); // [RQ16]
  chk_mon_lock: assert property (@(posedge clock) disable iff (!resetn)
    (func_ff[MUX_LO_POS +: MUX_W] == MUX_LOCK) |=> selectable_monitor_out == $past(lock_sync_ff[1]))
    else $error("monitor not showing lock"); // [RQ13]
  cov_ce_cycle: cover property (@(posedge clock) disable iff (!resetn) powered_down ##[1:200] !powered_down);
  cov_reset_seq: cover property (@(posedge clock) disable iff (!resetn) $fell(func_ff[CNT_RST_POS]));
  cov_init_load: cover property (@(posedge clock) disable iff (!resetn) init_pulse_ff);
endmodule
`default_nettype wire

// ---- bench/sslsq_host_model.sv ----
// host serial master model that drives the three-wire load port
`timescale 1ns/1ps
`default_nettype none
module sslsq_host_model (
  output logic serial_clock,  // idle low, runs only within frames
  output logic serial_in,     // serial data, changes while the clock is low
  output logic latch_strobe   // idle high between words
);
  // idle levels; the clock must be low while reset is applied
  initial begin
    serial_clock = 1'b0;
    serial_in    = 1'b0;
    latch_strobe = 1'b1;
  end

  // one latch write: strobe low, three bytes msb first, strobe high
  task automatic send(input logic [23:0] w);
    int i;
    latch_strobe = 1'b0;                // open the frame
    for (i = 23; i >= 0; i--) begin     // msb first, select bits last
      serial_in = w[i];
      #12;
      serial_clock = 1'b1;              // data set up before the rising edge, phase zero
      #24;
      serial_clock = 1'b0;              // 48 ns period, about 20.8 MHz, above the 20 MHz ceiling
      #12;
    end
    serial_in = ~w[0];                  // released line shows no stale bit
    #24;
    latch_strobe = 1'b1;                // raised only after the third byte
    #150;                               // strobe held high past 100 ns before the next word
  endtask
endmodule
`default_nettype wire

// ---- bench/sslsq_core_tb.sv ----
// self-checking bench for the serial load sequencer
`timescale 1ns/1ps
`default_nettype none
module sslsq_core_tb;
  import sslsq_pkg::*;
  logic              clock;           // 40 MHz core clock
  logic              resetn;          // async reset, active low
  logic              chip_enable;     // power control pin
  logic              lock_indicator;  // lock level from the loop
  wire               serial_clock;    // driven by the host model
  wire               serial_in;       // driven by the host model
  wire               latch_strobe;    // driven by the host model
  logic              mon;             // monitor output
  logic              pdn;             // power-down flag
  logic              held;            // counters at load point
  logic              cp_off;          // charge pump three-stated
  logic              settled;         // bias settle elapsed
  logic [WORD_W-1:0] ref_l;           // reference latch
  logic [WORD_W-1:0] ab_l;            // ab latch
  logic [WORD_W-1:0] fn_l;            // function latch
  logic [WORD_W-1:0] e_ref;           // expected reference latch
  logic [WORD_W-1:0] e_ab;            // expected ab latch
  logic [WORD_W-1:0] e_fn;            // expected function latch
  int                fail_count = 0;  // mismatches
  int                n_tests    = 0;  // comparisons

  sslsq_host_model sslsq_host_model_i (.serial_clock(serial_clock), .serial_in(serial_in),
    .latch_strobe(latch_strobe));
  sslsq_core sslsq_core_i (.clock(clock), .resetn(resetn), .serial_clock(serial_clock),
    .serial_in(serial_in), .latch_strobe(latch_strobe), .chip_enable(chip_enable),
    .lock_indicator(lock_indicator), .selectable_monitor_out(mon), .powered_down(pdn),
    .counters_held(held), .charge_pump_off(cp_off), .bias_settled(settled),
    .ref_latch(ref_l), .ab_latch(ab_l), .func_latch(fn_l));

  // core clock, 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_word(input string nm, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // wait n edges, then sample one step later so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // chip enable changes on a rising edge by non-blocking assignment
  task automatic set_ce(input logic v);
    @(posedge clock);
    chip_enable <= v;
  endtask

  // one word through the host; the model's strobe hold covers the 2-3 cycle update
  task automatic load(input logic [WORD_W-1:0] w);
    sslsq_host_model_i.send(w);
    if (w[1:0] == SEL_REF) e_ref = w;
    if (w[1:0] == SEL_AB) e_ab = w;
    if (w[1:0] == SEL_FUNC) e_fn = w;
    if (w[1:0] == SEL_INIT) e_fn = w;  // init word also fills the function latch
    cyc(2);
  endtask

  task automatic chk_latches;
    chk_word("ref_latch", e_ref, ref_l);
    chk_word("ab_latch", e_ab, ab_l);
    chk_word("func_latch", e_fn, fn_l);
  endtask

  // initialization word then function, reference and ab loads; each lands in its own latch
  task automatic t_select;
    load(24'h0000b3);
    chk_word("init_to_func", 24'h0000b0, {fn_l[23:2], 2'h0});
    load(24'h000002);
    chk_latches;
    load(24'h123454);
    chk_latches;
    load(24'habcde5);
    chk_latches;
    $display("test select done");
  endtask

  // counter reset bit: hold and three-state without power-down
  task automatic t_reset_bit;
    load(24'h000006);
    chk_bit("held", 1'b1, held);
    chk_bit("cp_off", 1'b1, cp_off);
    chk_bit("pdn", 1'b0, pdn);
    load(24'h000a28);
    load(24'h001231);
    chk_latches;
    load(24'h000002);
    chk_bit("held_off", 1'b0, held);
    chk_bit("cp_on", 1'b0, cp_off);
    $display("test reset bit done");
  endtask

  // chip enable method, then a second power cycle without reloading
  task automatic t_ce;
    set_ce(1'b0);
    cyc(1);
    chk_bit("pdn_now", 1'b1, pdn);
    chk_bit("held_pd", 1'b1, held);
    load(24'h000012);
    load(24'h00c800);
    load(24'h003c0d);
    chk_latches;
    set_ce(1'b1);
    cyc(36);
    chk_bit("settle_early", 1'b0, settled);
    chk_bit("pdn_off", 1'b0, pdn);
    chk_bit("held_run", 1'b0, held);
    cyc(10);
    chk_bit("settle_done", 1'b1, settled);
    set_ce(1'b0);
    cyc(3);
    set_ce(1'b1);
    cyc(46);
    chk_latches;
    chk_bit("held_again", 1'b0, held);
    $display("test chip enable done");
  endtask

  // monitor selections, lock followed both ways
  task automatic t_monitor;
    logic [2:0] ms [5] = '{MUX_ONE, MUX_LOCK, MUX_LOCK, MUX_RUN, 3'h0};
    logic       lk [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int i;
    for (i = 0; i < 5; i++) begin
      @(posedge clock);
      lock_indicator <= lk[i];
      load({17'h0, ms[i], 4'h2});
      cyc(4);
      chk_bit("monitor", ex[i], mon);
    end
    $display("test monitor done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence; host writes all latches before relying on output
  initial begin
    resetn = 1'b0;
    chip_enable = 1'b1;
    lock_indicator = 1'b0;
    e_ref = LATCH_RST;
    e_ab = LATCH_RST;
    e_fn = LATCH_RST;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    cyc(4);
    chk_latches;
    t_select;
    t_reset_bit;
    t_ce;
    t_monitor;
    end_sim;
  end

  // watchdog: the tests need about 26 us
  initial begin
    #150000;
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
